// ### hdl/smsi_core.sv
// Purpose: Serial command/response port, interrupt factors and mode control of a switch monitor
// Assumes: Serial clock idles low; chip select high between frames for many clk_sys cycles
// Notes:   Link logic is held clear from clk_sys while chip select is high
`timescale 1ns/1ps
`default_nettype none

module smsi_core
  import smsi_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       spi_sclk,
  input  wire logic       chip_select_n,
  input  wire logic       spi_si,
  output var  logic       spi_so,
  output var  logic       spi_so_oe,
  output var  logic       irq_n_out,
  output var  logic       irq_n_oe,
  output var  logic       wake_n_out,
  output var  logic       wake_n_oe,
  input  wire logic [7:0] source_switch_group_a,
  input  wire logic [5:0] source_switch_group_b,
  input  wire logic [7:0] bidir_switch_group,
  input  wire logic       test_mode_in,
  input  wire logic       thermal_shdn_in,
  input  wire logic       intermittent_en,
  output var  logic       src_on
);

  // ==========================================================================
  // Parameter checks
  if (STROBE_CYCLES < 1 || PERIOD_CYCLES <= STROBE_CYCLES) begin : g_bad_param
    $error("smsi_core: strobe must be at least one cycle and shorter than period");
  end

  // ==========================================================================
  // Synchronisers
  logic       csn_s1_q, csn_s2_q, csn_s3_q;
  logic       tst_s1_q, tst_s2_q;
  logic       tsd_s1_q, tsd_s2_q;
  logic       int_s1_q, int_s2_q;
  smsi_sw_s   sw_s1_q, sw_s2_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      csn_s1_q <= 1'b1;
      csn_s2_q <= 1'b1;
      csn_s3_q <= 1'b1;
    end else begin
      csn_s1_q <= chip_select_n;
      csn_s2_q <= csn_s1_q;
      csn_s3_q <= csn_s2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tst_s1_q <= 1'b0;
      tst_s2_q <= 1'b0;
      tsd_s1_q <= 1'b0;
      tsd_s2_q <= 1'b0;
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      sw_s1_q  <= '0;
      sw_s2_q  <= '0;
    end else begin
      tst_s1_q <= test_mode_in;
      tst_s2_q <= tst_s1_q;
      tsd_s1_q <= thermal_shdn_in;
      tsd_s2_q <= tsd_s1_q;
      int_s1_q <= intermittent_en;
      int_s2_q <= int_s1_q;
      sw_s1_q  <= '{grp_b: source_switch_group_b, grp_a: source_switch_group_a,
                    grp_z: bidir_switch_group};
      sw_s2_q  <= sw_s1_q;
    end
  end

  logic cs_fall_w;
  logic cs_rise_w;
  assign cs_fall_w = csn_s3_q & ~csn_s2_q;
  assign cs_rise_w = ~csn_s3_q & csn_s2_q;

  // ==========================================================================
  // Link side: receive and transmit on the serial clock
  logic                    link_clr_q;
  logic [FRAME_BITS-1:0]   rx_q;
  logic [5:0]              rx_cnt_q;
  logic [5:0]              tx_idx_q;
  logic [FRAME_BITS-1:0]   resp_q;

  // Held while select is high, so stray clocks are ignored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link_clr_q <= 1'b1;
    end else begin
      link_clr_q <= csn_s2_q;
    end
  end

  // Count saturates at 41 so longer frames stay detectable
  always_ff @(negedge spi_sclk or posedge link_clr_q) begin
    if (link_clr_q) begin
      rx_q     <= '0;
      rx_cnt_q <= 6'h00;
    end else begin
      rx_q     <= {rx_q[FRAME_BITS-2:0], spi_si};
      if (rx_cnt_q <= 6'(FRAME_BITS)) begin
        rx_cnt_q <= rx_cnt_q + 6'h01;
      end
    end
  end

  // Bit 39 is always 1, so it can sit in the cleared state
  always_ff @(posedge spi_sclk or posedge link_clr_q) begin
    if (link_clr_q) begin
      spi_so   <= 1'b1;
      tx_idx_q <= 6'h00;
    end else begin
      tx_idx_q <= tx_idx_q + 6'h01;
      if (tx_idx_q < 6'(FRAME_BITS - 1)) begin
        spi_so <= resp_q[6'(FRAME_BITS - 2) - tx_idx_q];
      end else begin
        spi_so <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      spi_so_oe <= 1'b0;
    end else begin
      spi_so_oe <= ~csn_s2_q;
    end
  end

  // ==========================================================================
  // Frame check and command decode at select rise
  logic        frame_ok_w;
  logic [5:0]  cmd_addr_w;
  logic [23:0] cmd_data_w;
  logic        apply_w;

  assign cmd_addr_w = rx_q[37:32];
  assign cmd_data_w = rx_q[31:8];
  // rx_q is quiet here: last serial edge is well before the sync delay
  assign frame_ok_w = (rx_cnt_q == 6'(FRAME_BITS))
                    && (rx_q[39:38] == DIR_CMD)
                    && (smsi_crc8(rx_q[39:8]) == rx_q[7:0]);
  assign apply_w    = cs_rise_w & frame_ok_w;

  logic [23:0] regs_q [16];
  logic        rb_pend_q;
  logic [23:0] rb_val_q;
  logic        sleep_q;
  logic        auto_en_q;
  logic        cmd_rst_w;
  logic        sw_chg_w;

  assign cmd_rst_w = apply_w & (cmd_addr_w == ADDR_RESET);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || cmd_rst_w) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= '0;
      end
    end else if (apply_w && cmd_addr_w[5:4] == 2'h0 && cmd_addr_w != ADDR_NULL) begin
      regs_q[cmd_addr_w[3:0]] <= cmd_data_w;
    end
  end

  // Result queued now, shown in the next frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rb_pend_q <= 1'b0;
      rb_val_q  <= '0;
    end else if (cs_rise_w) begin
      rb_pend_q <= apply_w & cmd_addr_w[ADDR_RB_BIT];
      if (apply_w && cmd_addr_w[ADDR_RB_BIT]) begin
        rb_val_q <= regs_q[cmd_addr_w[3:0]];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || cmd_rst_w) begin
      sleep_q   <= 1'b0;
      auto_en_q <= 1'b0;
    end else if (apply_w && cmd_addr_w == ADDR_MODE) begin
      sleep_q <= cmd_data_w[MODE_BIT];
    end else if (apply_w && cmd_addr_w == ADDR_AUTO) begin
      auto_en_q <= cmd_data_w[AUTO_BIT];
    end else if (sleep_q && auto_en_q && sw_chg_w) begin
      sleep_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_n_out <= 1'b0;
      wake_n_oe  <= 1'b1;
    end else begin
      wake_n_out <= 1'b0;
      wake_n_oe  <= ~sleep_q;
    end
  end

  // ==========================================================================
  // Switch monitoring
  smsi_src_e   src_q;
  logic [31:0] mon_cnt_q;
  smsi_sw_s    sw_q;
  logic        sample_w;

  // Continuous mode keeps the source on and samples every cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_q     <= SMSI_SRC_LIVE;
      mon_cnt_q <= '0;
    end else if (!int_s2_q) begin
      src_q     <= SMSI_SRC_LIVE;
      mon_cnt_q <= '0;
    end else begin
      if (mon_cnt_q == 32'(PERIOD_CYCLES - 1)) begin
        mon_cnt_q <= '0;
      end else begin
        mon_cnt_q <= mon_cnt_q + 32'h1;
      end
      case (src_q)
        SMSI_SRC_LIVE: begin
          if (mon_cnt_q == 32'(STROBE_CYCLES - 1)) begin
            src_q <= SMSI_SRC_OFF;
          end
        end
        SMSI_SRC_OFF: begin
          if (mon_cnt_q == 32'(PERIOD_CYCLES - 1)) begin
            src_q <= SMSI_SRC_LIVE;
          end
        end
        default: src_q <= SMSI_SRC_LIVE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_on <= 1'b1;
    end else begin
      src_on <= (src_q == SMSI_SRC_LIVE);
    end
  end

  // Sample at the end of the strobe, once the source has settled
  assign sample_w = !int_s2_q
                  || (src_q == SMSI_SRC_LIVE && mon_cnt_q == 32'(STROBE_CYCLES - 1));
  assign sw_chg_w = sample_w && (sw_s2_q != sw_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sw_q <= '0;
    end else if (sample_w) begin
      sw_q <= sw_s2_q;
    end
  end

  // ==========================================================================
  // Interrupt factors
  logic [4:0]  flags_q;
  logic [4:0]  rep_q;
  logic [4:0]  pend_q;
  logic [4:0]  evt_w;

  always_comb begin
    evt_w            = 5'h00;
    evt_w[FLG_TEST]  = tst_s2_q;
    evt_w[FLG_THERM] = tsd_s2_q;
    evt_w[FLG_RST]   = cmd_rst_w;
    evt_w[FLG_ERR]   = cs_rise_w & ~frame_ok_w;
    evt_w[FLG_SW]    = sw_chg_w;
  end

  // Snapshot what the frame reports; only those bits may be cleared
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rep_q  <= 5'h00;
      pend_q <= 5'h00;
    end else if (cs_fall_w) begin
      rep_q  <= flags_q;
      pend_q <= 5'h00;
    end else if (!csn_s2_q) begin
      pend_q <= pend_q | evt_w;
    end
  end

  // New events win over the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RST;
    end else if (cs_rise_w) begin
      flags_q <= (flags_q & ~(rep_q & ~pend_q)) | evt_w;
    end else begin
      flags_q <= flags_q | evt_w;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= 1'b1;
    end else begin
      irq_n_out <= 1'b0;
      irq_n_oe  <= |flags_q;
    end
  end

  // ==========================================================================
  // Response frame, built when select falls
  logic [31:0] body_w;

  always_comb begin
    if (rb_pend_q) begin
      body_w = {RESP_HDR, flags_q, rb_val_q};
    end else begin
      body_w = {RESP_HDR, flags_q, 1'b0, sleep_q, sw_s2_q};
    end
  end

  // resp_q is held all frame; first serial edge comes long after the load
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resp_q <= '0;
    end else if (cs_fall_w) begin
      resp_q <= {body_w, smsi_crc8(body_w)};
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  irq_low_a: assert property ((flags_q != 5'h00) |=> irq_n_oe)
    else $error("interrupt not driven with a latched factor");

  por_irq_a: assert property ($fell(sys_rst) |-> irq_n_oe && flags_q[FLG_RST])
    else $error("interrupt not asserted after reset");

  irq_release_a: assert property ((cs_rise_w && frame_ok_w && cmd_addr_w != ADDR_RESET
      && evt_w == 5'h00 && (flags_q & ~rep_q) == 5'h00 && pend_q == 5'h00)
      ##1 (evt_w == 5'h00) |=> !irq_n_oe)
    else $error("interrupt not released after clean frame");

  mode_cmd_a: assert property ((apply_w && cmd_addr_w == ADDR_MODE && cmd_data_w[MODE_BIT]) |=> sleep_q)
    else $error("sleep command not applied");

  mode_norm_a: assert property ((apply_w && cmd_addr_w == ADDR_MODE && !cmd_data_w[MODE_BIT]) |=> !sleep_q)
    else $error("normal command not applied");

  wake_pin_a: assert property (sleep_q ##1 sleep_q |-> !wake_n_oe)
    else $error("wake line driven in sleep");

  auto_wake_a: assert property ((sleep_q && auto_en_q && sw_chg_w && !apply_w)
      |=> !sleep_q && flags_q[FLG_SW] ##1 irq_n_oe)
    else $error("automatic wake failed");

  err_flag_a: assert property ((cs_rise_w && !frame_ok_w) |=> flags_q[FLG_ERR] && !rb_pend_q)
    else $error("bad frame not flagged");

  resp_hdr_a: assert property (cs_fall_w |=> resp_q[39:37] == RESP_HDR
      && resp_q[36:32] == $past(flags_q) && resp_q[7:0] == smsi_crc8(resp_q[39:8]))
    else $error("response header or crc wrong");

  resp_mode_a: assert property ((cs_fall_w && !rb_pend_q)
      |=> resp_q[30] == $past(sleep_q) && resp_q[29:8] == $past(sw_s2_q))
    else $error("status body wrong");

  rb_next_a: assert property ((apply_w && cmd_addr_w[ADDR_RB_BIT]) |=> rb_pend_q)
    else $error("read-back not queued");

  rb_out_a: assert property ((cs_fall_w && rb_pend_q) |=> resp_q[31:8] == rb_val_q)
    else $error("read-back value missing");

  flag_keep_a: assert property ((cs_rise_w && pend_q[FLG_SW]) |=> flags_q[FLG_SW])
    else $error("mid-frame factor lost");

endmodule : smsi_core

`default_nettype wire

// ### include/smsi_pkg.sv
// Purpose: Shared constants and types for the switch monitor serial and interrupt block
// Assumes: Host is the serial master; device logic runs on clk_sys plus the serial clock
// Notes:   Command addresses, read-back encoding and CRC constants are local choices
package smsi_pkg;

  // ==========================================================================
  // Frame layout
  localparam int          FRAME_BITS  = 40;
  localparam logic [1:0]  DIR_CMD     = 2'h1;
  localparam logic [2:0]  RESP_HDR    = 3'h4;
  localparam logic [7:0]  CRC_POLY    = 8'h1d;
  localparam logic [7:0]  CRC_INIT    = 8'hff;

  // ==========================================================================
  // Command addresses (bits 37..32 of a host frame)
  localparam logic [5:0]  ADDR_NULL   = 6'h00;
  localparam logic [5:0]  ADDR_AUTO   = 6'h0e;
  localparam logic [5:0]  ADDR_MODE   = 6'h0f;
  localparam logic [5:0]  ADDR_RESET  = 6'h1f;
  localparam int          ADDR_RB_BIT = 5;
  localparam int          MODE_BIT    = 23;
  localparam int          AUTO_BIT    = 23;

  // ==========================================================================
  // Interrupt factor positions within the 5-bit flag field
  localparam int          FLG_TEST    = 4;
  localparam int          FLG_THERM   = 3;
  localparam int          FLG_RST     = 2;
  localparam int          FLG_ERR     = 1;
  localparam int          FLG_SW      = 0;
  localparam logic [4:0]  FLAGS_RST   = 5'h04;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          STROBE_US     = 125;
  localparam int          PERIOD_US     = 10000;
  localparam int          STROBE_CYC    = (STROBE_US * 1000) / CLK_PERIOD_NS;
  localparam int          PERIOD_CYC    = (PERIOD_US * 1000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [5:0] grp_b;
    logic [7:0] grp_a;
    logic [7:0] grp_z;
  } smsi_sw_s;

  typedef enum logic [0:0] {
    SMSI_SRC_OFF  = 1'b0,
    SMSI_SRC_LIVE = 1'b1
  } smsi_src_e;

  function automatic logic [7:0] smsi_crc8(input logic [31:0] d);
    logic [7:0] c;
    logic       fb;
    c  = CRC_INIT;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : smsi_crc8

endpackage : smsi_pkg

// ### tb/smsi_host_model.sv
// Purpose: Serial master standing in for the host controller
// Assumes: Link clock idles low and is still between frames; 80 ns period
// Notes:   Frames of fewer than 40 bits are sent only when a test asks for them
`timescale 1ns/1ps
`default_nettype none

module smsi_host_model (
  output var  logic spi_sclk,
  output var  logic chip_select_n,
  output var  logic spi_si,
  input  wire logic spi_so,
  input  wire logic spi_so_oe
);
  initial begin
    spi_sclk      = 1'b0;
    chip_select_n = 1'b1;
    spi_si        = 1'b0;
  end

  // ==========================================================================
  // One frame, MSB first; reply bit taken just before each rising edge
  task automatic xfer(input logic [39:0] tx, input int nbits, output logic [39:0] rx);
    rx            = '0;
    // Offset keeps link edges away from system clock edges
    #1.3 chip_select_n = 1'b0;
    #60;
    for (int i = 39; i > 39 - nbits; i--) begin
      #20 spi_si = tx[i];
      // An undriven reply line reads as the inverse of its last level
      #20 rx[i] = spi_so_oe ? spi_so : ~spi_so;
      spi_sclk = 1'b1;
      #40 spi_sclk = 1'b0;
    end
    #60 chip_select_n = 1'b1;
    // Released data line must not keep its last value
    spi_si = ~spi_si;
    #400;
  endtask : xfer
endmodule : smsi_host_model

`default_nettype wire

// ### tb/smsi_core_tb.sv
// Purpose: Self-checking bench for the switch monitor serial and interrupt block
// Assumes: Host model drives the link; bench drives switches and fault inputs
// Notes:   Short strobe and period parameters keep intermittent runs brief
`timescale 1ns/1ps
`default_nettype none

module smsi_core_tb;
  import smsi_pkg::*;

  logic        clk_sys, sys_rst, spi_sclk, chip_select_n, spi_si, spi_so, spi_so_oe;
  logic        irq_n_out, irq_n_oe, wake_n_out, wake_n_oe, src_on;
  logic        test_mode_in, thermal_shdn_in, intermittent_en, irq_l, wake_l;
  smsi_sw_s    sw, s1, s2;
  logic [39:0] tx, rx;
  int          fail_count, tests_run, cycles, on_cnt;
  localparam int STB = 4;
  localparam int PER = 16;

  // Both open-drain lines have pull-ups
  assign irq_l  = irq_n_oe ? irq_n_out : 1'b1;
  assign wake_l = wake_n_oe ? wake_n_out : 1'b1;

  smsi_core #(.STROBE_CYCLES(STB), .PERIOD_CYCLES(PER)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .chip_select_n(chip_select_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .wake_n_out(wake_n_out), .wake_n_oe(wake_n_oe),
    .source_switch_group_a(sw.grp_a), .source_switch_group_b(sw.grp_b),
    .bidir_switch_group(sw.grp_z), .test_mode_in(test_mode_in),
    .thermal_shdn_in(thermal_shdn_in), .intermittent_en(intermittent_en), .src_on(src_on)
  );

  smsi_host_model host_u (
    .spi_sclk(spi_sclk), .chip_select_n(chip_select_n), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Expected frames
  function automatic logic [39:0] seal(input logic [31:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return {d, c};
  endfunction : seal

  function automatic logic [39:0] st(input logic [4:0] f, input logic m, input smsi_sw_s s);
    return seal({3'b100, f, 1'b0, m, s});
  endfunction : st

  function automatic logic [39:0] cmd(input logic [5:0] a, input logic [23:0] d);
    return seal({DIR_CMD, a, d});
  endfunction : cmd

  // ==========================================================================
  // Checks and access
  task automatic chk40(input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk40

  task automatic chk1(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk1

  task automatic frame(input logic [39:0] t, input logic [39:0] e);
    logic [39:0] r;
    host_u.xfer(t, 40, r);
    chk40(e, r);
  endtask : frame

  task automatic wait_irq(input logic v);
    for (int i = 0; i < 400 && irq_l !== v; i++) @(negedge clk_sys);
    chk1(v, irq_l);
  endtask : wait_irq

  task automatic set_sw(input smsi_sw_s s);
    @(posedge clk_sys);
    sw <= s;
  endtask : set_sw

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // Ceiling well above the roughly 26000 cycles the tests take
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    sys_rst         = 1'b1;
    sw              = '0;
    test_mode_in    = 1'b0;
    thermal_shdn_in = 1'b0;
    intermittent_en = 1'b0;
    s1              = '{6'h2a, 8'h5a, 8'hc3};
    s2              = '{6'h15, 8'h0f, 8'h81};
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk1(1'b0, irq_l);
    chk1(1'b0, wake_l);
    chk1(1'b0, spi_so_oe);
    frame(cmd(ADDR_NULL, 24'h0), st(FLAGS_RST, 1'b0, '0));
    wait_irq(1'b1);
    $display("test power_up done");

    set_sw(s1);
    wait_irq(1'b0);
    frame(cmd(ADDR_NULL, 24'h0), st(5'h01, 1'b0, s1));
    wait_irq(1'b1);
    $display("test switch_change done");

    for (int m = 1; m >= 0; m--) begin
      frame(cmd(ADDR_MODE, {m[0], 23'h0}), st(5'h00, ~m[0], s1));
      chk1(m[0], wake_l);
      frame(cmd(ADDR_NULL, 24'h0), st(5'h00, m[0], s1));
    end
    frame(cmd(ADDR_AUTO, 24'h800000), st(5'h00, 1'b0, s1));
    frame(cmd(ADDR_MODE, 24'h800000), st(5'h00, 1'b0, s1));
    set_sw(s2);
    wait_irq(1'b0);
    frame(cmd(ADDR_NULL, 24'h0), st(5'h01, 1'b0, s2));
    chk1(1'b0, wake_l);
    $display("test modes done");

    // Each bad frame carries a sleep request that must be thrown away
    for (int k = 0; k < 3; k++) begin
      tx = (k == 1) ? seal({2'b10, ADDR_MODE, 24'h800000}) : cmd(ADDR_MODE, 24'h800000) ^ 40'(k == 0);
      host_u.xfer(tx, (k == 2) ? 39 : 40, rx);
      chk1(1'b0, irq_l);
      frame(cmd(ADDR_NULL, 24'h0), st(5'h02, 1'b0, s2));
      wait_irq(1'b1);
    end
    $display("test bad_frames done");

    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      if (j == 0) thermal_shdn_in <= 1'b1;
      else test_mode_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      thermal_shdn_in <= 1'b0;
      test_mode_in    <= 1'b0;
      wait_irq(1'b0);
      frame(cmd(ADDR_NULL, 24'h0), st(j ? 5'h10 : 5'h08, 1'b0, s2));
      wait_irq(1'b1);
    end
    $display("test fault_factors done");

    // Factor reported in this frame and raised again inside it
    set_sw(s1);
    wait_irq(1'b0);
    fork
      frame(cmd(ADDR_NULL, 24'h0), st(5'h01, 1'b0, s1));
      begin
        #1000;
        set_sw(s2);
      end
    join
    chk1(1'b0, irq_l);
    frame(cmd(ADDR_NULL, 24'h0), st(5'h01, 1'b0, s2));
    wait_irq(1'b1);
    $display("test mid_frame done");

    frame(cmd(6'h01, 24'habcdef), st(5'h00, 1'b0, s2));
    frame(cmd(6'h02, 24'h123456), st(5'h00, 1'b0, s2));
    frame(cmd(6'h21, 24'h0), st(5'h00, 1'b0, s2));
    frame(cmd(6'h22, 24'h0), seal({3'b100, 5'h00, 24'habcdef}));
    frame(cmd(ADDR_NULL, 24'h0), seal({3'b100, 5'h00, 24'h123456}));
    $display("test read_back done");

    // Reset command clears registers; its factor shows in the next frame
    frame(cmd(ADDR_RESET, 24'h0), st(5'h00, 1'b0, s2));
    chk1(1'b0, irq_l);
    frame(cmd(6'h21, 24'h0), st(5'h04, 1'b0, s2));
    frame(cmd(ADDR_NULL, 24'h0), seal({3'b100, 5'h00, 24'h000000}));
    wait_irq(1'b1);
    $display("test reset_command done");

    chk1(1'b1, src_on);
    @(posedge clk_sys);
    intermittent_en <= 1'b1;
    on_cnt = 0;
    repeat (8) @(posedge clk_sys);
    // Any whole number of periods holds the same count of strobe cycles
    repeat (4 * PER) begin
      @(negedge clk_sys);
      on_cnt += int'(src_on);
    end
    chk1(1'b1, on_cnt == 4 * STB);
    set_sw(s1);
    wait_irq(1'b0);
    frame(cmd(ADDR_NULL, 24'h0), st(5'h01, 1'b0, s1));
    $display("test intermittent done");
    finish_test();
  end
endmodule : smsi_core_tb

`default_nettype wire
